// File: design/fri_top.sv
// FIFO fill status, range checks and interrupt output
// Overview of operation
// - Seven-bit read-only count of results held in the FIFO, level bits 6:0.
// - Writing 1 to control bit 0 empties the FIFO, count returns to zero.
// - Control bit 6 lets a FIFO overwrite drive the interrupt output.
// - Control bits 5..1 enable 7/8, 6/8, 4/8, 2/8, 1/8 threshold interrupts.
// - Modes 1-3 raise data-ready interrupt only while its enable, reset 1, is set.
// - Mode 4 ignores the data-ready enable bit.
// - Input enable bits 5:0 let each channel interrupt when out of range.
// - Status bits 5:0 set when that channel is found out of range.
// - Reading the status register clears the six channel bits.
// - Threshold status bits follow the live level and never latch.
// - Status bit 14 sets on a FIFO overwrite.
// - Status bits 13..9 show 7/8, 6/8, 4/8, 2/8, 1/8 full.
// - Bits 4:3 pick result, delta or filter output for the limit compare.
// - Bits 2:0 set filter cutoff, scan rate over 39.0625 doubled per code.
// - Beyond 64 results the newest overwrites the oldest, flagging overwrite.
// - Out of range means the compared value lies outside lower..upper.
`timescale 1ns/1ps
`include "fri_params.svh"
module fri_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the serial control port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Conversion results and FIFO drain
  input wire fri_pkg::fri_result_t result,
  input wire logic fifo_pop,
  input wire logic [2:0] seq_mode,
  // Per-channel limits
  input wire fri_pkg::fri_bounds_t channel_lower_bound,
  input wire fri_pkg::fri_bounds_t channel_upper_bound,
  // Status towards the data path and the pin
  output logic irq_out,
  output logic [6:0] fifo_fill_count,
  output logic fifo_flush,
  output logic out_of_range_flag,
  output logic overwrite_flag,
  output logic [16:0] cutoff_div_x16
);
  import fri_pkg::*;

  fri_state_t s_q;
  fri_state_t s_d;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [4:0] thresholds(input logic [6:0] c);
    thresholds = {c >= `FRI_THR_7_8, c >= `FRI_THR_6_8,
                  c >= `FRI_THR_4_8, c >= `FRI_THR_2_8,
                  c >= `FRI_THR_1_8};
  endfunction : thresholds

  function automatic logic outside(input logic [23:0] v,
                                   input logic [23:0] lo,
                                   input logic [23:0] hi);
    outside = ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
  endfunction : outside

  // ****************************************************************
  // Decoded accesses and combinational terms
  // ****************************************************************
  logic wr_ctrl;
  logic wr_inen;
  logic wr_hpf;
  logic rd_stat;
  logic flush_req;
  logic ch_ok;
  logic push;
  logic pop;
  logic overwrite;
  logic [4:0] thr;
  logic [23:0] cmp_val;
  logic cmp_on;
  logic range_now;
  logic [5:0] ch_hit;
  logic rdy_en;
  logic [15:0] stat_word;
  logic [15:0] rd_word;

  assign wr_ctrl = reg_wr && (reg_addr == `FRI_ADDR_CTRL);
  assign wr_inen = reg_wr && (reg_addr == `FRI_ADDR_INEN);
  assign wr_hpf = reg_wr && (reg_addr == `FRI_ADDR_HPF);
  assign rd_stat = reg_rd && (reg_addr == `FRI_ADDR_STAT);
  assign flush_req = wr_ctrl && reg_wdata[`FRI_CTRL_FLUSH];
  assign ch_ok = result.ch < `FRI_NCH;
  assign push = result.valid;
  assign pop = fifo_pop && (s_q.count != 7'h00);
  // Full FIFO taking a result with no drain loses its oldest entry
  assign overwrite = push && !pop && (s_q.count == `FRI_DEPTH);
  assign thr = thresholds(s_q.count);

  // Compare source mux; code 3 disables the check
  always_comb
  begin
    cmp_val = result.data;
    cmp_on = 1'b1;
    case (s_q.highpass_compare_control[4:3])
      `FRI_CMP_RESULT: cmp_val = result.data;
      `FRI_CMP_DELTA: cmp_val = result.data - s_q.prev[result.ch];
      `FRI_CMP_HPF: cmp_val = result.highpass_compare_control;
      default: cmp_on = 1'b0;
    endcase
  end

  assign range_now = push && ch_ok && cmp_on &&
    outside(cmp_val, channel_lower_bound[result.ch],
            channel_upper_bound[result.ch]);
  assign ch_hit = range_now ? 6'(6'h01 << result.ch) : 6'h00;

  // Mode 4 treats the data-ready enable as always on
  assign rdy_en = (seq_mode == `FRI_MODE_SEQ4) ||
                  s_q.inen[`FRI_INEN_RDY];

  assign stat_word = {1'b0, s_q.ovw, thr, 3'h0, s_q.chst};

  always_comb
  begin
    case (reg_addr)
      `FRI_ADDR_LEVEL: rd_word = {9'h000, s_q.count};
      `FRI_ADDR_CTRL: rd_word = {9'h000, s_q.ctrl};
      `FRI_ADDR_INEN: rd_word = {8'h00, s_q.inen};
      `FRI_ADDR_STAT: rd_word = stat_word;
      `FRI_ADDR_HPF: rd_word = {11'h000, s_q.highpass_compare_control};
      default: rd_word = 16'h0000;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.flush = flush_req;
    s_d.rvalid = reg_rd;
    if (reg_rd)
    begin
      s_d.rdata = rd_word;
    end
    // Fill count; flush outranks a same-cycle push
    if (flush_req)
    begin
      s_d.count = 7'h00;
    end
    else if (!overwrite)
    begin
      s_d.count = 7'(s_q.count + {6'h00, push} - {6'h00, pop});
    end
    // Sticky bits: the new event wins over the read that clears
    if (rd_stat)
    begin
      s_d.chst = 6'h00;
      s_d.ovw = 1'b0;
    end
    s_d.chst = s_d.chst | ch_hit;
    if (overwrite)
    begin
      s_d.ovw = 1'b1;
    end
    // Data-ready pending clears once the host drains a result
    if (pop || flush_req)
    begin
      s_d.rdy = 1'b0;
    end
    if (push && rdy_en && (seq_mode != 3'h0))
    begin
      s_d.rdy = 1'b1;
    end
    if (wr_ctrl)
    begin
      // Flush bit is a strobe and reads back as zero
      s_d.ctrl = {reg_wdata[6:1], 1'b0};
    end
    if (wr_inen)
    begin
      s_d.inen = {reg_wdata[7], 1'b0, reg_wdata[5:0]};
    end
    if (wr_hpf)
    begin
      s_d.highpass_compare_control = reg_wdata[4:0];
    end
    if (push && ch_ok)
    begin
      s_d.prev[result.ch] = result.data;
    end
    s_d.range_hit = range_now;
    s_d.ovw_entry = overwrite;
    s_d.count_out = s_d.count;
    s_d.div = 17'(`FRI_DIV_BASE_X16 << s_q.highpass_compare_control[2:0]);
    s_d.irq = (s_q.ovw && s_q.ctrl[`FRI_CTRL_OVW]) ||
              |(thr & s_q.ctrl[5:1]) ||
              |(s_q.chst & s_q.inen[5:0]) ||
              s_q.rdy;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.ctrl <= `FRI_CTRL_RST;
      s_q.inen <= `FRI_INEN_RST;
      s_q.highpass_compare_control <= `FRI_HPF_RST;
      s_q.div <= `FRI_DIV_BASE_X16;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign irq_out = s_q.irq;
  assign fifo_fill_count = s_q.count_out;
  assign fifo_flush = s_q.flush;
  assign out_of_range_flag = s_q.range_hit;
  assign overwrite_flag = s_q.ovw_entry;
  assign cutoff_div_x16 = s_q.div;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_count_bounded: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.count <= `FRI_DEPTH)
    else $error("fill count above depth");

  a_flush_empties: assert property (@(posedge clk) disable iff (!rst_n)
    flush_req |=> (s_q.count == 7'h00) && fifo_flush)
    else $error("flush did not empty the FIFO");

  a_ovw_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.ovw && s_q.ctrl[`FRI_CTRL_OVW]) |=> irq_out)
    else $error("overwrite did not raise interrupt");

  a_thr_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (|(thr & s_q.ctrl[5:1])) |=> irq_out)
    else $error("threshold did not raise interrupt");

  a_rdy_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (push && seq_mode != 3'h0 && seq_mode != `FRI_MODE_SEQ4
     && !s_q.inen[`FRI_INEN_RDY] && !s_q.rdy) |=> !s_q.rdy)
    else $error("data ready set while disabled");

  a_mode4_rdy: assert property (@(posedge clk) disable iff (!rst_n)
    (push && seq_mode == `FRI_MODE_SEQ4) |=> s_q.rdy ##1 irq_out)
    else $error("mode 4 data ready not raised");

  a_ch_irq: assert property (@(posedge clk) disable iff (!rst_n)
    (|(s_q.chst & s_q.inen[5:0])) |=> irq_out)
    else $error("channel range did not raise interrupt");

  a_range_sets: assert property (@(posedge clk) disable iff (!rst_n)
    range_now |=> s_q.chst[$past(result.ch)] && out_of_range_flag)
    else $error("out of range not recorded");

  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_stat && !range_now) |=> s_q.chst == 6'h00)
    else $error("status read did not clear channel bits");

  a_thr_live: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == `FRI_ADDR_STAT |=>
      reg_rdata[13:9] == thresholds($past(s_q.count)))
    else $error("threshold bits not live");

  // A flush in the same cycle still empties the FIFO
  a_ovw_flag: assert property (@(posedge clk) disable iff (!rst_n)
    overwrite |=> s_q.ovw && overwrite_flag &&
      s_q.count == ($past(flush_req) ? 7'h00 : `FRI_DEPTH))
    else $error("overwrite not flagged");

  // Divisor is registered from the code held one cycle earlier
  a_div_code: assert property (@(posedge clk) disable iff (!rst_n)
    cutoff_div_x16 ==
      17'(`FRI_DIV_BASE_X16 << $past(s_q.highpass_compare_control[2:0])))
    else $error("cutoff divisor wrong");

  a_irq_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    (!s_q.rdy && !(s_q.ovw && s_q.ctrl[`FRI_CTRL_OVW]) &&
     !(|(thr & s_q.ctrl[5:1])) && !(|(s_q.chst & s_q.inen[5:0])))
    |=> !irq_out)
    else $error("interrupt without enabled cause");

  a_cmp_reserved: assert property (@(posedge clk) disable iff (!rst_n)
    (s_q.highpass_compare_control[4:3] == 2'h3) |-> !range_now)
    else $error("reserved compare code flagged a channel");
endmodule : fri_top

// File: inc/fri_params.svh
// Constants of the FIFO status and range interrupt block
`ifndef FRI_PARAMS_SVH
`define FRI_PARAMS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define FRI_ADDR_LEVEL 8'h14
`define FRI_ADDR_CTRL 8'h15
`define FRI_ADDR_INEN 8'h16
`define FRI_ADDR_STAT 8'h17
`define FRI_ADDR_HPF 8'h18
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define FRI_CTRL_FLUSH 0
`define FRI_CTRL_OVW 6
`define FRI_INEN_RDY 7
`define FRI_STAT_OVW 14
`define FRI_CTRL_RST 7'h00
`define FRI_INEN_RST 8'h80
`define FRI_HPF_RST 5'h00
// ****************************************************************
// FIFO geometry, thresholds and filter divisor
// ****************************************************************
`define FRI_DEPTH 7'h40
`define FRI_THR_7_8 7'h38
`define FRI_THR_6_8 7'h30
`define FRI_THR_4_8 7'h20
`define FRI_THR_2_8 7'h10
`define FRI_THR_1_8 7'h08
`define FRI_NCH 3'h6
`define FRI_MODE_SEQ4 3'h4
`define FRI_CMP_RESULT 2'h0
`define FRI_CMP_DELTA 2'h1
`define FRI_CMP_HPF 2'h2
// Base divisor 39.0625 scaled by 16
`define FRI_DIV_BASE_X16 17'h00271
`endif

// File: inc/fri_pkg.sv
// Types of the FIFO status and range interrupt block
package fri_pkg;
  // One conversion result entering the FIFO
  typedef struct packed {
    logic valid;
    logic [2:0] ch;
    logic [23:0] data;
    logic [23:0] highpass_compare_control;
  } fri_result_t;

  typedef logic [5:0][23:0] fri_bounds_t;

  // Whole state of the block
  typedef struct packed {
    logic [6:0] count;
    logic ovw;
    logic [5:0] chst;
    logic rdy;
    logic [6:0] ctrl;
    logic [7:0] inen;
    logic [4:0] highpass_compare_control;
    logic [5:0][23:0] prev;
    logic [15:0] rdata;
    logic rvalid;
    logic irq;
    logic flush;
    logic range_hit;
    logic ovw_entry;
    logic [6:0] count_out;
    logic [16:0] div;
  } fri_state_t;
endpackage : fri_pkg

// File: sim/fri_host_model.sv
// Host model driving the register port of the status block
`timescale 1ns/1ps
module fri_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  import fri_pkg::*;
  // ****************************************************************
  // Byte accesses, driven on the falling edge
  // ****************************************************************
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // A flush is a write of 1 to control bit 0
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Released bus shows the inverse, never the stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rvalid;
  endtask : rd
endmodule : fri_host_model

// File: sim/test_fri_top.sv
// Directed testbench of the FIFO status and range interrupt block
`timescale 1ns/1ps
module test_fri_top;
  import fri_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata;
  logic reg_wr, reg_rd, reg_rvalid, irq_out, fifo_flush;
  logic out_of_range_flag, overwrite_flag;
  logic [15:0] reg_rdata;
  logic [6:0] fifo_fill_count;
  logic [16:0] cutoff_div_x16;
  fri_result_t result = '0;
  logic fifo_pop = 1'b0;
  logic [2:0] seq_mode = 3'h0;
  fri_bounds_t lo = {6{24'hFFFF9C}};
  fri_bounds_t hi = {6{24'h000064}};
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clk = ~clk;
  fri_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .result(result),
    .fifo_pop(fifo_pop), .seq_mode(seq_mode),
    .channel_lower_bound(lo), .channel_upper_bound(hi),
    .irq_out(irq_out), .fifo_fill_count(fifo_fill_count),
    .fifo_flush(fifo_flush), .out_of_range_flag(out_of_range_flag),
    .overwrite_flag(overwrite_flag), .cutoff_div_x16(cutoff_div_x16));
  fri_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    u_host.rd(a, d, v);
    chk({16'h0000, v}, 17'h00001);
    chk({1'b0, d}, {1'b0, exp});
  endtask : rdc
  // Back-to-back pushes; returns while the last push's flags stand
  task automatic push(input int n, input logic [2:0] c,
                      input logic [23:0] d, input logic [23:0] h);
    repeat (n)
    begin
      @(negedge clk);
      result = {1'b1, c, d, h};
    end
    @(negedge clk);
    result = {1'b0, ~c, ~d, ~h};
  endtask : push
  task automatic pop();
    @(negedge clk);
    fifo_pop = 1'b1;
    @(negedge clk);
    fifo_pop = 1'b0;
  endtask : pop
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk(cutoff_div_x16, 17'h00271);
    rdc(8'h14, 16'h0000);
    rdc(8'h15, 16'h0000);
    rdc(8'h16, 16'h0080);
    rdc(8'h17, 16'h0000);
    rdc(8'h18, 16'h0000);
    rdc(8'h20, 16'h0000);
    u_host.wr(8'h14, 8'h55);
    rdc(8'h14, 16'h0000);
    u_host.wr(8'h16, 8'hFF);
    rdc(8'h16, 16'h00BF);
    u_host.wr(8'h16, 8'h80);
    $display("test 1 done");
    push(8, 3'h0, 24'h0, 24'h0);
    chk(fifo_fill_count, 17'h00008);
    rdc(8'h14, 16'h0008);
    rdc(8'h17, 16'h0200);
    u_host.wr(8'h15, 8'h02);
    @(negedge clk);
    chk(irq_out, 1'b1);
    pop();
    @(negedge clk);
    chk(irq_out, 1'b0);
    rdc(8'h17, 16'h0000);
    $display("test 2 done");
    u_host.wr(8'h15, 8'h40);
    push(57, 3'h0, 24'h0, 24'h0);
    rdc(8'h17, 16'h3E00);
    chk(irq_out, 1'b0);
    push(1, 3'h0, 24'h0, 24'h0);
    chk(overwrite_flag, 1'b1);
    @(negedge clk);
    chk(irq_out, 1'b1);
    rdc(8'h14, 16'h0040);
    rdc(8'h17, 16'h7E00);
    rdc(8'h17, 16'h3E00);
    u_host.wr(8'h15, 8'h01);
    chk(fifo_flush, 1'b1);
    rdc(8'h14, 16'h0000);
    rdc(8'h15, 16'h0000);
    $display("test 3 done");
    u_host.wr(8'h16, 8'h04);
    push(1, 3'h2, 24'h0000C8, 24'h0);
    chk(out_of_range_flag, 1'b1);
    @(negedge clk);
    chk(irq_out, 1'b1);
    rdc(8'h17, 16'h0004);
    rdc(8'h17, 16'h0000);
    chk(irq_out, 1'b0);
    u_host.wr(8'h18, 8'h08);
    push(1, 3'h2, 24'h0000FA, 24'h0);
    chk(out_of_range_flag, 1'b0);
    u_host.wr(8'h18, 8'h18);
    push(1, 3'h2, 24'h0000C8, 24'h0);
    chk(out_of_range_flag, 1'b0);
    u_host.wr(8'h18, 8'h10);
    push(1, 3'h2, 24'h0, 24'hFFFE00);
    chk(out_of_range_flag, 1'b1);
    for (int c = 0; c < 8; c++)
    begin
      u_host.wr(8'h18, 8'(c));
      // Divisor follows the code one cycle after the write
      @(negedge clk);
      chk(cutoff_div_x16, 17'h00271 << c);
    end
    u_host.wr(8'h18, 8'hFF);
    rdc(8'h18, 16'h001F);
    u_host.wr(8'h18, 8'h00);
    // Channel 6 is counted but never range checked
    push(1, 3'h6, 24'h0000C8, 24'h0);
    chk(out_of_range_flag, 1'b0);
    rdc(8'h17, 16'h0004);
    $display("test 4 done");
    u_host.wr(8'h16, 8'h00);
    seq_mode = 3'h1;
    push(1, 3'h0, 24'h0, 24'h0);
    @(negedge clk);
    chk(irq_out, 1'b0);
    u_host.wr(8'h16, 8'h80);
    push(1, 3'h0, 24'h0, 24'h0);
    @(negedge clk);
    chk(irq_out, 1'b1);
    pop();
    @(negedge clk);
    chk(irq_out, 1'b0);
    seq_mode = 3'h4;
    u_host.wr(8'h16, 8'h00);
    push(1, 3'h0, 24'h0, 24'h0);
    @(negedge clk);
    chk(irq_out, 1'b1);
    $display("test 5 done");
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk(irq_out, 1'b0);
    chk(fifo_fill_count, 17'h00000);
    rdc(8'h16, 16'h0080);
    $display("test 6 done");
    report_and_stop();
  end
endmodule : test_fri_top
